// ### hw/pemls_pkg.sv
package pemls_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [4:0] EVENT_MASK_ADDR = 5'h16;
  localparam logic [4:0] LINK_STATUS_ADDR = 5'h17;
  localparam logic [15:0] EVENT_MASK_RST = 16'h8000;
  localparam logic [15:0] REG_RST = 16'h0000;

  // ********************************************************************
  // Event latch positions
  // ********************************************************************
  localparam int EVT_LINK_LOSS = 10;
  localparam int EVT_LINK_GAIN = 9;
  localparam int EVT_SYMBOL_ERROR_EVENT = 8;
  localparam int EVT_QUAL_WARN = 6;
  localparam logic [15:0] EVT_LINK_GROUP = 16'h0740;
  localparam logic [15:0] EVT_EXT_SRC = 16'hC8AF;

  // ********************************************************************
  // Status word fields
  // ********************************************************************
  localparam int ST_LINK_OK = 15;
  localparam int ST_TX_MODE_HI = 14;
  localparam int ST_TX_MODE_LO = 13;
  localparam int ST_LOC_OK = 12;
  localparam int ST_REM_OK = 11;
  localparam int ST_LOCK = 10;
  localparam int ST_SSD = 9;
  localparam int ST_ESD = 8;
  localparam int ST_SQI_HI = 7;
  localparam int ST_SQI_LO = 5;
  localparam int ST_RX_ERR = 4;
  localparam int ST_TX_ERR = 3;
  localparam int ST_PORT_HI = 2;
  localparam int ST_LATCH_LO = 3;

  // ********************************************************************
  // Serial management frame
  // ********************************************************************
  localparam logic [1:0] SMI_OP_READ = 2'b10;
  localparam logic [1:0] SMI_OP_WRITE = 2'b01;
  localparam logic [5:0] SMI_PRE_LEN = 6'h20;
  localparam logic [3:0] SMI_HDR_LAST = 4'hB;
  localparam logic [3:0] SMI_DATA_LAST = 4'hF;

  typedef enum logic [2:0] {
    SM_IDLE = 3'b000,
    SM_START = 3'b001,
    SM_HDR = 3'b011,
    SM_TA = 3'b010,
    SM_DATA = 3'b110
  } pemls_smi_state_e;

endpackage

// ### hw/pemls_reg_if.sv
`timescale 1ns/10ps
interface pemls_reg_if;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  modport master(output addr, output wdata, output wr, output rd, input rdata);
  modport target(input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ### hw/pemls_smi_frame.sv
`timescale 1ns/10ps
module pemls_smi_frame
  import pemls_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
)
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Serial management pins.
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Register access.
  pemls_reg_if.master reg_bus
);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic mdc_s1_r, mdc_s2_r, mdc_s3_r, mdio_s1_r, mdio_s2_r;
  logic rise;
  logic bit_in;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_s3_r <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end
    else
    begin
      mdc_s1_r <= mdc_i;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      mdio_s1_r <= mdio_i;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  assign rise = mdc_s2_r & ~mdc_s3_r;
  assign bit_in = mdio_s2_r;

  // ********************************************************************
  // Frame engine
  // ********************************************************************
  pemls_smi_state_e st_r, st_nxt;
  logic [5:0] pre_r, pre_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [11:0] hdr_r, hdr_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic isrd_r, isrd_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic out_r, out_nxt, oe_r, oe_nxt;

  always_comb
  begin
    st_nxt = st_r;
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    sh_nxt = sh_r;
    isrd_nxt = isrd_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    out_nxt = out_r;
    oe_nxt = oe_r;
    // Read data is captured one cycle after the header, before any later MDC edge.
    if (rd_r)
      sh_nxt = reg_bus.rdata;
    if (rise)
    begin
      case (st_r)
        SM_IDLE:
        begin
          if (bit_in)
          begin
            if (pre_r != SMI_PRE_LEN)
              pre_nxt = pre_r + 6'h01;
          end
          else
          begin
            if (pre_r == SMI_PRE_LEN)
              st_nxt = SM_START;
            pre_nxt = '0;
          end
        end
        SM_START:
        begin
          st_nxt = bit_in ? SM_HDR : SM_IDLE;
          cnt_nxt = '0;
        end
        SM_HDR:
        begin
          hdr_nxt = {hdr_r[10:0], bit_in};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == SMI_HDR_LAST)
          begin
            cnt_nxt = '0;
            st_nxt = SM_IDLE;
            if (hdr_nxt[9:5] == PHY_ADDR &&
                (hdr_nxt[11:10] == SMI_OP_READ || hdr_nxt[11:10] == SMI_OP_WRITE))
            begin
              st_nxt = SM_TA;
              isrd_nxt = (hdr_nxt[11:10] == SMI_OP_READ);
              rd_nxt = isrd_nxt;
            end
          end
        end
        SM_TA:
        begin
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == 4'h0)
          begin
            oe_nxt = isrd_r;
            out_nxt = 1'b0;
          end
          else
          begin
            st_nxt = SM_DATA;
            cnt_nxt = '0;
            if (isrd_r)
            begin
              out_nxt = sh_r[15];
              sh_nxt = {sh_r[14:0], 1'b0};
            end
          end
        end
        SM_DATA:
        begin
          cnt_nxt = cnt_r + 4'h1;
          if (isrd_r)
          begin
            out_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
            if (cnt_r == SMI_DATA_LAST)
            begin
              oe_nxt = 1'b0;
              out_nxt = 1'b0;
              st_nxt = SM_IDLE;
            end
          end
          else
          begin
            sh_nxt = {sh_r[14:0], bit_in};
            if (cnt_r == SMI_DATA_LAST)
            begin
              wr_nxt = 1'b1;
              st_nxt = SM_IDLE;
            end
          end
        end
        default:
          st_nxt = SM_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= SM_IDLE;
      pre_r <= '0;
      cnt_r <= '0;
      hdr_r <= '0;
      sh_r <= '0;
      isrd_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      sh_r <= sh_nxt;
      isrd_r <= isrd_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign reg_bus.addr = hdr_r[4:0];
  assign reg_bus.wdata = sh_r;
  assign reg_bus.rd = rd_r;
  assign reg_bus.wr = wr_r;
  assign mdio_o = out_r;
  assign mdio_oe_o = oe_r;

endmodule

// ### hw/pemls_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Event mask read/write, only bit 15 set.
// - Status bits 2:0 report port state.
// - Status bits 14:13 report transmitter state.
// - Local receiver OK bit latches low.
// - Far receiver OK bit latches low.
// - Start delimiter error latches high until read.
// - End delimiter error latches high until read.
// - Status bits 7:5 report signal quality class.
// - Receive error latches high until read.
// - Transmit error latches high until read.
// - Link control off zeroes all but state.
// - Link loss and gain events latch.
// - Quality warning latches below limit with link.
// - Sleep or undervoltage clears link event group.
module pemls_top
  import pemls_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
)
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Serial management pins.
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Link state from the port logic.
  input wire logic link_control_i,
  input wire logic link_up_i,
  input wire logic [1:0] tx_mode_i,
  input wire logic local_receiver_ok_i,
  input wire logic far_receiver_ok_i,
  input wire logic descrambler_lock_i,
  input wire logic start_delimiter_error_i,
  input wire logic end_delimiter_error_i,
  input wire logic [2:0] signal_quality_class_i,
  input wire logic receive_error_i,
  input wire logic transmit_error_i,
  input wire logic [2:0] port_state_code_i,
  // Event sources and event latch control.
  input wire logic [15:0] event_src_i,
  input wire logic symbol_error_event_i,
  input wire logic [2:0] quality_warn_limit_i,
  input wire logic sleep_request_i,
  input wire logic undervoltage_standby_i,
  input wire logic event_clear_i,
  // Interrupt indication.
  output logic irq_pending_o
);

  pemls_reg_if reg_bus();

  pemls_smi_frame #(
    .PHY_ADDR(PHY_ADDR)
  ) u_frame (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .reg_bus(reg_bus)
  );

  // ********************************************************************
  // Event mask and event latches
  // ********************************************************************
  logic [15:0] mask_r, mask_nxt, evt_r, evt_nxt, evt_set;
  logic irq_r, irq_nxt, link_ok, link_ok_d_r, mask_wr_seen_r, mask_wr_seen_nxt;

  assign link_ok = link_control_i & link_up_i;

  always_comb
  begin
    mask_nxt = mask_r;
    mask_wr_seen_nxt = mask_wr_seen_r;
    // Reserved bits are stored as written; the master keeps them at zero.
    if (reg_bus.wr && reg_bus.addr == EVENT_MASK_ADDR)
    begin
      mask_nxt = reg_bus.wdata;
      mask_wr_seen_nxt = 1'b1;
    end
    evt_set = event_src_i & EVT_EXT_SRC;
    evt_set[EVT_LINK_LOSS] = link_ok_d_r & ~link_ok;
    evt_set[EVT_LINK_GAIN] = ~link_ok_d_r & link_ok;
    evt_set[EVT_SYMBOL_ERROR_EVENT] = symbol_error_event_i;
    evt_set[EVT_QUAL_WARN] = link_ok & (signal_quality_class_i < quality_warn_limit_i);
    evt_nxt = evt_r;
    if (event_clear_i)
      evt_nxt = '0;
    if (sleep_request_i || undervoltage_standby_i)
      evt_nxt = evt_nxt & ~EVT_LINK_GROUP;
    // A new event wins over any clear in the same cycle.
    evt_nxt = evt_nxt | evt_set;
    irq_nxt = |(evt_nxt & mask_nxt);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mask_r <= EVENT_MASK_RST;
      mask_wr_seen_r <= 1'b0;
      evt_r <= REG_RST;
      irq_r <= 1'b0;
      link_ok_d_r <= 1'b0;
    end
    else
    begin
      mask_r <= mask_nxt;
      mask_wr_seen_r <= mask_wr_seen_nxt;
      evt_r <= evt_nxt;
      irq_r <= irq_nxt;
      link_ok_d_r <= link_ok;
    end
  end

  assign irq_pending_o = irq_r;

  // ********************************************************************
  // Communication status word
  // ********************************************************************
  logic rd_clr;
  logic loc_r, loc_nxt, rem_r, rem_nxt, ssd_r, ssd_nxt, esd_r, esd_nxt;
  logic rxe_r, rxe_nxt, txe_r, txe_nxt;
  logic [15:0] stat_word;

  assign rd_clr = reg_bus.rd && reg_bus.addr == LINK_STATUS_ADDR;

  always_comb
  begin
    // Latch-low bits reload the live level on a read, so a read shows the drop once.
    loc_nxt = rd_clr ? local_receiver_ok_i : (loc_r & local_receiver_ok_i);
    rem_nxt = rd_clr ? far_receiver_ok_i : (rem_r & far_receiver_ok_i);
    ssd_nxt = (ssd_r & ~rd_clr) | start_delimiter_error_i;
    esd_nxt = (esd_r & ~rd_clr) | end_delimiter_error_i;
    rxe_nxt = (rxe_r & ~rd_clr) | receive_error_i;
    txe_nxt = (txe_r & ~rd_clr) | transmit_error_i;
    if (!link_control_i)
    begin
      loc_nxt = 1'b0;
      rem_nxt = 1'b0;
      ssd_nxt = 1'b0;
      esd_nxt = 1'b0;
      rxe_nxt = 1'b0;
      txe_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      loc_r <= 1'b0;
      rem_r <= 1'b0;
      ssd_r <= 1'b0;
      esd_r <= 1'b0;
      rxe_r <= 1'b0;
      txe_r <= 1'b0;
    end
    else
    begin
      loc_r <= loc_nxt;
      rem_r <= rem_nxt;
      ssd_r <= ssd_nxt;
      esd_r <= esd_nxt;
      rxe_r <= rxe_nxt;
      txe_r <= txe_nxt;
    end
  end

  always_comb
  begin
    stat_word = REG_RST;
    stat_word[ST_PORT_HI:0] = port_state_code_i;
    if (link_control_i)
    begin
      stat_word[ST_LINK_OK] = link_up_i;
      stat_word[ST_TX_MODE_HI:ST_TX_MODE_LO] = tx_mode_i;
      stat_word[ST_LOC_OK] = loc_r;
      stat_word[ST_REM_OK] = rem_r;
      stat_word[ST_LOCK] = descrambler_lock_i;
      stat_word[ST_SSD] = ssd_r;
      stat_word[ST_ESD] = esd_r;
      stat_word[ST_SQI_HI:ST_SQI_LO] = signal_quality_class_i;
      stat_word[ST_RX_ERR] = rxe_r;
      stat_word[ST_TX_ERR] = txe_r;
    end
  end

  always_comb
  begin
    case (reg_bus.addr)
      EVENT_MASK_ADDR: reg_bus.rdata = mask_r;
      LINK_STATUS_ADDR: reg_bus.rdata = stat_word;
      default: reg_bus.rdata = REG_RST;
    endcase
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  AST_MASK_RESET: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !mask_wr_seen_r |-> mask_r == EVENT_MASK_RST)
    else $error("Event mask left its reset value without a write.");

  AST_PORT_STATE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rd_clr |-> reg_bus.rdata[ST_PORT_HI:0] == port_state_code_i)
    else $error("Port state field does not follow the port.");

  AST_TX_MODE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (rd_clr && link_control_i) |-> reg_bus.rdata[ST_TX_MODE_HI:ST_TX_MODE_LO] == tx_mode_i)
    else $error("Transmitter state field is wrong.");

  AST_LOC_LATCH_LOW: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (!local_receiver_ok_i && !rd_clr) ##1 (!rd_clr)[*2] |-> !stat_word[ST_LOC_OK])
    else $error("Local receiver drop was not held.");

  AST_REM_LATCH_LOW: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(far_receiver_ok_i) |=> !stat_word[ST_REM_OK])
    else $error("Far receiver drop was not held.");

  AST_SSD_HOLD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (start_delimiter_error_i && link_control_i) ##1 (link_control_i && !rd_clr)[*3]
      |-> stat_word[ST_SSD])
    else $error("Start delimiter error not held until read.");

  AST_ESD_SET: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (end_delimiter_error_i && link_control_i) |=> link_control_i |-> stat_word[ST_ESD])
    else $error("End delimiter error not latched.");

  AST_RX_ERR_CLR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (rd_clr && !receive_error_i) |=> !stat_word[ST_RX_ERR])
    else $error("Receive error not cleared by a read.");

  AST_TX_ERR_SET: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (transmit_error_i && link_control_i) |=> (!link_control_i || txe_r))
    else $error("Transmit error not latched.");

  AST_LINK_CTRL_OFF: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (!link_control_i)[*2] |-> stat_word[15:ST_LATCH_LO] == 13'h0000)
    else $error("Status fields not zero with link control off.");

  AST_LINK_EDGE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(link_ok) |=> evt_r[EVT_LINK_LOSS] && $past(link_ok_d_r))
    else $error("Link loss event not latched.");

  AST_IRQ: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (evt_set[15] && mask_nxt[15]) |=> irq_pending_o)
    else $error("Enabled event did not raise the interrupt.");

endmodule

// ### sim/pemls_mdio_master.sv
`timescale 1ns/10ps
// ****************************************
// Serial management master model
// ****************************************
module pemls_mdio_master
  import pemls_pkg::*;
#(
  parameter int HALF = 8
)
(
  // Clock.
  input wire logic mclk_i,
  // Management pins.
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  // The clock rests low between frames and the bus pull-up sets the idle level.
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
  end

  // Data is sampled just before the rising edge, so the device gets a full period.
  task automatic tick(input logic b, input logic oe, output logic s);
    mdio_o <= b;
    mdio_oe_o <= oe;
    repeat (HALF) @(posedge mclk_i);
    s = mdio_i;
    mdc_o <= 1'b1;
    repeat (HALF) @(posedge mclk_i);
    mdc_o <= 1'b0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic s;
    hdr = {32'hFFFF_FFFF, 2'b01, op, phy, ra};
    tail = {2'b10, wd};
    rd = 16'h0000;
    for (int i = 45; i >= 0; i--)
      tick(hdr[i], 1'b1, s);
    for (int i = 17; i >= 0; i--)
    begin
      tick(tail[i], op == SMI_OP_WRITE, s);
      if (i < 16)
        rd[i] = s;
    end
    tick(1'b1, 1'b0, s);
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
  import pemls_pkg::*;
  localparam logic [4:0] PHY = 5'h05;
  logic mclk_i = 1'b0;
  logic arst_n = 1'b0;
  logic mdc, m_mdio, m_oe, d_mdio, d_oe, line, irq;
  logic lctl = 1'b0, lup = 1'b0, lok = 1'b1, fok = 1'b1, lock = 1'b0;
  logic ssd = 1'b0, esd = 1'b0, rxe = 1'b0, txe = 1'b0, sym = 1'b0;
  logic slp = 1'b0, uvs = 1'b0, eclr = 1'b0, lk_q = 1'b0;
  logic [1:0] tx = 2'h0;
  logic [2:0] signal_quality_class = 3'h0, st = 3'h0, qlim = 3'h0;
  logic [15:0] esrc = 16'h0000;
  logic [31:0] rnd = 32'h0000_7282;
  int error_cnt = 0, checks = 0, lh = 0, ll = 0, evt = 0, mask = 32'h0000_8000;

  always #25 mclk_i = ~mclk_i;
  assign line = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);

  pemls_mdio_master i_pemls_mdio_master (.mclk_i(mclk_i), .mdio_i(line), .mdc_o(mdc),
    .mdio_o(m_mdio), .mdio_oe_o(m_oe));

  pemls_top #(.PHY_ADDR(PHY)) i_pemls_top (.mclk_i(mclk_i), .arst_n_i(arst_n), .mdc_i(mdc),
    .mdio_i(line), .mdio_o(d_mdio), .mdio_oe_o(d_oe), .link_control_i(lctl), .link_up_i(lup),
    .tx_mode_i(tx), .local_receiver_ok_i(lok), .far_receiver_ok_i(fok),
    .descrambler_lock_i(lock), .start_delimiter_error_i(ssd), .end_delimiter_error_i(esd),
    .signal_quality_class_i(signal_quality_class), .receive_error_i(rxe), .transmit_error_i(txe),
    .port_state_code_i(st), .event_src_i(esrc), .symbol_error_event_i(sym),
    .quality_warn_limit_i(qlim), .sleep_request_i(slp), .undervoltage_standby_i(uvs),
    .event_clear_i(eclr), .irq_pending_o(irq));

  // ****************************************
  // Reference model and helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic test_done();
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic fr(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                    input logic [15:0] wd, output logic [15:0] v);
    i_pemls_mdio_master.frame(op, phy, ra, wd, v);
  endtask

  task automatic wr_mask(input logic [15:0] v);
    logic [15:0] d;
    fr(SMI_OP_WRITE, PHY, EVENT_MASK_ADDR, v & 16'hCFEF, d);
    mask = v & 16'hCFEF;
  endtask

  // Expectation is formed after the frame, since inputs hold still during it.
  task automatic st_chk();
    logic [15:0] v;
    fr(SMI_OP_READ, PHY, LINK_STATUS_ADDR, 16'h0000, v);
    if (lctl)
      chk(v, {lup, tx, ll[1], ll[0], lock, lh[3], lh[2], signal_quality_class, lh[1], lh[0], st});
    else
      chk(v, {13'h0000, st});
    lh = 0;
    ll = lctl ? 3 : 0;
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge mclk_i);
    {ssd, esd, rxe, txe, lok, fok} <= {m[5:2], ~m[1:0]};
    @(posedge mclk_i);
    {ssd, esd, rxe, txe, lok, fok} <= 6'h03;
    lh = lh | m[5:2];
    ll = ll & ~m[1:0];
  endtask

  // Sampled mid-cycle, away from the edge that updates both the flop and the model.
  task automatic ev_chk();
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({15'h0000, irq}, {15'h0000, |(evt[15:0] & mask[15:0])});
  endtask

  task automatic ev(input logic [3:0] m);
    @(posedge mclk_i);
    {eclr, slp, uvs, sym} <= m;
    @(posedge mclk_i);
    {eclr, slp, uvs, sym} <= 4'h0;
    ev_chk();
  endtask

  // Sets are applied after clears so that a set in the same cycle wins.
  always @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      evt = 0;
      lk_q = 1'b0;
    end
    else
    begin
      if (eclr)
        evt = 0;
      if (slp | uvs)
        evt = evt & 32'h0000_F8BF;
      evt = evt | (esrc & EVT_EXT_SRC) | (sym << 8);
      if (lk_q && !(lctl && lup))
        evt = evt | 32'h0000_0400;
      if (!lk_q && lctl && lup)
        evt = evt | 32'h0000_0200;
      if (lctl && lup && signal_quality_class < qlim)
        evt = evt | 32'h0000_0040;
      lk_q = lctl & lup;
    end
  end

  initial
  begin
    repeat (45000) @(posedge mclk_i);
    error_cnt++;
    test_done();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [15:0] v;
    repeat (5) @(posedge mclk_i);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk_i);
    fr(SMI_OP_READ, PHY, EVENT_MASK_ADDR, 16'h0000, v);
    chk(v, 16'h8000);
    st_chk();
    lctl <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge mclk_i);
      st <= i[2:0];
      signal_quality_class <= i[2:0];
      tx <= i[1:0];
      {lup, lock} <= rnd[1:0];
      st_chk();
    end
    for (int j = 0; j < 2; j++)
    begin
      pulse(j ? 6'b010101 : 6'b101010);
      st_chk();
      st_chk();
    end
    pulse(6'h3F);
    @(posedge mclk_i);
    lctl <= 1'b0;
    lh = 0;
    ll = 0;
    st_chk();
    @(posedge mclk_i);
    lctl <= 1'b1;
    st_chk();
    rnd = lfsr(rnd);
    wr_mask(rnd[15:0]);
    fr(SMI_OP_READ, PHY, EVENT_MASK_ADDR, 16'h0000, v);
    chk(v, mask[15:0]);
    fr(SMI_OP_WRITE, PHY + 5'h01, EVENT_MASK_ADDR, 16'h0000, v);
    fr(SMI_OP_READ, PHY + 5'h01, EVENT_MASK_ADDR, 16'h0000, v);
    chk(v, 16'hFFFF);
    fr(SMI_OP_WRITE, PHY, 5'h1F, 16'hFFFF, v);
    fr(SMI_OP_READ, PHY, 5'h1F, 16'h0000, v);
    chk(v, 16'h0000);
    fr(2'b11, PHY, EVENT_MASK_ADDR, 16'h0000, v);
    chk(v, 16'hFFFF);
    fr(SMI_OP_READ, PHY, EVENT_MASK_ADDR, 16'h0000, v);
    chk(v, mask[15:0]);
    wr_mask(16'h8000);
    ev(4'h8);
    @(posedge mclk_i);
    esrc <= 16'hFFFF;
    @(posedge mclk_i);
    esrc <= 16'h0000;
    ev_chk();
    ev(4'h8);
    wr_mask(16'h0400);
    @(posedge mclk_i);
    lup <= 1'b1;
    ev(4'h8);
    @(posedge mclk_i);
    lup <= 1'b0;
    ev_chk();
    ev(4'h4);
    wr_mask(16'h0200);
    @(posedge mclk_i);
    lup <= 1'b1;
    ev_chk();
    ev(4'h2);
    wr_mask(16'h0100);
    ev(4'h1);
    ev(4'h4);
    wr_mask(16'h0040);
    @(posedge mclk_i);
    qlim <= 3'h4;
    signal_quality_class <= 3'h3;
    ev_chk();
    @(posedge mclk_i);
    signal_quality_class <= 3'h5;
    ev(4'h2);
    // A reset in mid-run must bring the mask back to its default.
    @(posedge mclk_i);
    arst_n <= 1'b0;
    repeat (5) @(posedge mclk_i);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk_i);
    mask = 32'h0000_8000;
    fr(SMI_OP_READ, PHY, EVENT_MASK_ADDR, 16'h0000, v);
    chk(v, 16'h8000);
    ev_chk();
    test_done();
  end
endmodule
